// >>> crce_pkg.sv
// What this block does
// R1: Polynomial up to 16 bits, software set.
// R2: Any 16-bit seed loaded before data.
// R3: Control 0 bit 1 selects shift direction.
// R4: Control 0 bit 4 selects zero augmentation.
// R5: Enable bit 7 low holds engine reset.
// R6: Start bit 6 runs or stops shifter.
// R7: Busy bit 5 while shifting or pending.
// R8: Full bit 0 while data unconsumed.
// R9: Control 1 bits 7:4 word length minus one.
// R10: Control 1 bits 3:0 polynomial length minus one.
// R11: Low data byte write loads the word.
// R12: Accumulator bytes readable, writable, reset zero.
// R13: Control 0 bits 3:2 read zero.
// R14: Data from scanner or from software.
// R15: Polynomial register enables each feedback term except term zero, which is always on.
// R16: One data bit per clock while running.
package crce_pkg;
	localparam int CRCE_ADDR_W = 4;
	localparam logic [3:0] CRCE_OFS_CTRL0 = 4'h0;
	localparam logic [3:0] CRCE_OFS_CTRL1 = 4'h1;
	localparam logic [3:0] CRCE_OFS_IN_HI = 4'h2;
	localparam logic [3:0] CRCE_OFS_IN_LO = 4'h3;
	localparam logic [3:0] CRCE_OFS_ACC_HI = 4'h4;
	localparam logic [3:0] CRCE_OFS_ACC_LO = 4'h5;
	localparam logic [3:0] CRCE_OFS_SHF_HI = 4'h6;
	localparam logic [3:0] CRCE_OFS_SHF_LO = 4'h7;
	localparam logic [3:0] CRCE_OFS_POLY_HI = 4'h8;
	localparam logic [3:0] CRCE_OFS_POLY_LO = 4'h9;
	localparam logic [3:0] CRCE_OFS_INT_STAT = 4'hA;
	localparam logic [3:0] CRCE_OFS_INT_MASK = 4'hB;
	// Control 0 bit positions.
	localparam int CRCE_C0_FULL = 0;
	localparam int CRCE_C0_DIR = 1;
	localparam int CRCE_C0_AUG = 4;
	localparam int CRCE_C0_BUSY = 5;
	localparam int CRCE_C0_GO = 6;
	localparam int CRCE_C0_EN = 7;
	localparam logic [7:0] CRCE_C0_WMASK = 8'hD2;
	// Control 1 fields.
	localparam int CRCE_C1_WLEN_LSB = 4;
	localparam int CRCE_C1_POLY_LSB = 0;
	// Interrupt status bits.
	localparam int CRCE_IRQ_WORD_DONE = 0;
	localparam int CRCE_IRQ_DATA_TAKEN = 1;
	localparam logic [7:0] CRCE_IRQ_IMPL = 8'h03;
	localparam logic [7:0] CRCE_RST8 = 8'h00;
	localparam logic [15:0] CRCE_RST16 = 16'h0000;
	localparam logic [3:0] CRCE_TOP_BIT = 4'hF;
	localparam logic [4:0] CRCE_CNT_ZERO = 5'h00;
	localparam logic [4:0] CRCE_CNT_ONE = 5'h01;

	// Bits 0..len set, all above clear.
	function automatic logic [15:0] crce_len_mask(input logic [3:0] len);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			m[i] = (4'(i) <= len);
		end
		return m;
	endfunction
endpackage

// >>> crce_step.sv
`timescale 1ns/100ps
module crce_step import crce_pkg::*; (
	// Accumulator state and configuration
	input wire logic [15:0] acc,
	input wire logic [15:0] poly,
	input wire logic [3:0] poly_msb,
	input wire logic shift_right,
	input wire logic auto_augment,
	// Incoming data bit
	input wire logic data_bit,
	// Folded result
	output logic [15:0] acc_next
);
	function automatic logic [15:0] reflect(input logic [15:0] p, input logic [3:0] len);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			if (4'(i) <= len) begin
				r[i] = p[len - 4'(i)];
			end
		end
		return r;
	endfunction

	wire [15:0] mask = crce_len_mask(poly_msb); // see R10
	wire [15:0] poly_l = poly & mask; // see R1 see R15
	wire [15:0] poly_r = reflect(poly_l, poly_msb);
	// Auto mode folds the bit straight into the feedback, which equals appending zeros.
	wire fb_l = auto_augment ? (acc[poly_msb] ^ data_bit) : acc[poly_msb]; // see R4
	wire fb_r = auto_augment ? (acc[0] ^ data_bit) : acc[0];
	wire [15:0] ins_l = auto_augment ? 16'h0000 : {15'h0000, data_bit};
	wire [15:0] ins_r = auto_augment ? 16'h0000 : (16'(data_bit) << poly_msb);
	wire [15:0] sh_l = ((acc << 1) | ins_l) & mask;
	wire [15:0] sh_r = ((acc & mask) >> 1) | ins_r;
	wire [15:0] res_l = sh_l ^ (fb_l ? poly_l : 16'h0000);
	wire [15:0] res_r = sh_r ^ (fb_r ? poly_r : 16'h0000);
	assign acc_next = shift_right ? res_r : res_l; // see R3
endmodule // crce_step

// >>> crce_engine.sv
`timescale 1ns/100ps
module crce_engine import crce_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [CRCE_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Memory scanner data path
	input wire logic scan_valid,
	input wire logic [15:0] scan_data,
	output logic scan_ready,
	// Interrupt
	output logic irq
);
	logic [7:0] ctrl0_q;
	logic [7:0] ctrl1_q;
	logic [15:0] data_q;
	logic full_q;
	logic [15:0] acc_q;
	logic [15:0] shreg_q;
	logic [4:0] bits_left_q;
	logic [15:0] poly_q;
	logic [7:0] int_stat_q;
	logic [7:0] int_mask_q;
	logic [7:0] rdata_q;
	logic scan_ready_q;
	logic irq_q;
	logic [7:0] ctrl0_d;
	logic [7:0] int_stat_d;
	logic [15:0] acc_d;
	logic [15:0] shreg_d;
	logic [4:0] bits_left_d;
	logic full_d;
	logic [15:0] data_d;

	// Address decode.
	wire wr_c0 = reg_wr && (reg_addr == CRCE_OFS_CTRL0);
	wire wr_c1 = reg_wr && (reg_addr == CRCE_OFS_CTRL1);
	wire wr_in_hi = reg_wr && (reg_addr == CRCE_OFS_IN_HI);
	wire wr_in_lo = reg_wr && (reg_addr == CRCE_OFS_IN_LO);
	wire wr_acc_hi = reg_wr && (reg_addr == CRCE_OFS_ACC_HI);
	wire wr_acc_lo = reg_wr && (reg_addr == CRCE_OFS_ACC_LO);
	wire wr_poly_hi = reg_wr && (reg_addr == CRCE_OFS_POLY_HI);
	wire wr_poly_lo = reg_wr && (reg_addr == CRCE_OFS_POLY_LO);
	wire wr_stat = reg_wr && (reg_addr == CRCE_OFS_INT_STAT);
	wire wr_mask = reg_wr && (reg_addr == CRCE_OFS_INT_MASK);

	// Control fields.
	wire en = ctrl0_q[CRCE_C0_EN];
	wire go = ctrl0_q[CRCE_C0_GO];
	wire dir_right = ctrl0_q[CRCE_C0_DIR];
	wire auto_aug = ctrl0_q[CRCE_C0_AUG];
	wire [3:0] wlen_m1 = ctrl1_q[CRCE_C1_WLEN_LSB +: 4];
	wire [3:0] poly_msb = ctrl1_q[CRCE_C1_POLY_LSB +: 4];

	// Engine state.
	wire shifter_empty = (bits_left_q == CRCE_CNT_ZERO);
	wire shifting = en && go && !shifter_empty; // see R16
	wire load = en && go && shifter_empty && full_q;
	wire busy = !shifter_empty || (full_q && go); // see R7
	// Low data byte writes win over the scanner; the scanner keeps valid high until taken.
	wire scan_take = en && scan_valid && scan_ready_q && !wr_in_lo; // see R14
	wire sw_load = en && wr_in_lo; // see R11
	wire data_bit = dir_right ? shreg_q[0] : shreg_q[CRCE_TOP_BIT];
	wire [15:0] step_acc;
	wire [15:0] load_word = dir_right ? data_q : (data_q << (CRCE_TOP_BIT - wlen_m1));
	wire word_done = shifting && (bits_left_q == CRCE_CNT_ONE);
	wire [7:0] events = {6'h00, load, word_done};
	wire [7:0] ctrl0_view = {ctrl0_q[7:6], busy, ctrl0_q[CRCE_C0_AUG], 2'b00,
		ctrl0_q[CRCE_C0_DIR], full_q}; // see R13
	wire [15:0] poly_eff = {poly_q[15:1], 1'b1};

	crce_step u_step (
		.acc(acc_q),
		.poly(poly_eff),
		.poly_msb(poly_msb),
		.shift_right(dir_right),
		.auto_augment(auto_aug),
		.data_bit(data_bit),
		.acc_next(step_acc)
	);

	// Read mux; unmapped addresses read zero.
	wire [7:0] rd_mux =
		(reg_addr == CRCE_OFS_CTRL0) ? ctrl0_view :
		(reg_addr == CRCE_OFS_CTRL1) ? ctrl1_q :
		(reg_addr == CRCE_OFS_IN_HI) ? data_q[15:8] :
		(reg_addr == CRCE_OFS_IN_LO) ? data_q[7:0] :
		(reg_addr == CRCE_OFS_ACC_HI) ? acc_q[15:8] :
		(reg_addr == CRCE_OFS_ACC_LO) ? acc_q[7:0] :
		(reg_addr == CRCE_OFS_SHF_HI) ? shreg_q[15:8] :
		(reg_addr == CRCE_OFS_SHF_LO) ? shreg_q[7:0] :
		(reg_addr == CRCE_OFS_POLY_HI) ? poly_q[15:8] :
		(reg_addr == CRCE_OFS_POLY_LO) ? poly_eff[7:0] :
		(reg_addr == CRCE_OFS_INT_STAT) ? int_stat_q :
		(reg_addr == CRCE_OFS_INT_MASK) ? int_mask_q : CRCE_RST8;

	// Control 0: busy and full bits are views only, never stored.
	always_comb begin
		ctrl0_d = ctrl0_q;
		if (wr_c0) begin
			ctrl0_d = reg_wdata & CRCE_C0_WMASK;
		end
	end

	// Data register pair.
	always_comb begin
		data_d = data_q;
		full_d = full_q;
		if (!en) begin
			full_d = 1'b0; // see R5
		end else if (load) begin
			full_d = 1'b0; // see R8
		end
		if (wr_in_hi) begin
			data_d[15:8] = reg_wdata;
		end
		if (sw_load) begin
			data_d[7:0] = reg_wdata;
			full_d = 1'b1; // see R8 see R11
		end else if (scan_take) begin
			data_d = scan_data;
			full_d = 1'b1;
		end
	end

	// Shifter and accumulator.
	always_comb begin
		acc_d = acc_q;
		shreg_d = shreg_q;
		bits_left_d = bits_left_q;
		if (!en) begin
			shreg_d = CRCE_RST16; // see R5
			bits_left_d = CRCE_CNT_ZERO;
		end else if (shifting) begin
			acc_d = step_acc; // see R16
			shreg_d = dir_right ? (shreg_q >> 1) : (shreg_q << 1); // see R3
			bits_left_d = bits_left_q - CRCE_CNT_ONE;
		end else if (load) begin
			shreg_d = load_word;
			bits_left_d = {1'b0, wlen_m1} + CRCE_CNT_ONE; // see R9
		end
		// A direct write loads the seed or overrides the running value.
		if (wr_acc_hi) begin
			acc_d[15:8] = reg_wdata; // see R2 see R12
		end
		if (wr_acc_lo) begin
			acc_d[7:0] = reg_wdata; // see R12
		end
	end

	// Sticky status: a new event wins over a write-one clear in the same cycle.
	always_comb begin
		int_stat_d = int_stat_q;
		if (wr_stat) begin
			int_stat_d = int_stat_q & ~reg_wdata;
		end
		int_stat_d = (int_stat_d | events) & CRCE_IRQ_IMPL;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl0_q <= CRCE_RST8;
			ctrl1_q <= CRCE_RST8;
			data_q <= CRCE_RST16;
			full_q <= 1'b0;
			acc_q <= CRCE_RST16;
			shreg_q <= CRCE_RST16;
			bits_left_q <= CRCE_CNT_ZERO;
		end else begin
			ctrl0_q <= ctrl0_d;
			ctrl1_q <= wr_c1 ? reg_wdata : ctrl1_q; // see R9 see R10
			data_q <= data_d;
			full_q <= full_d;
			acc_q <= acc_d;
			shreg_q <= shreg_d;
			bits_left_q <= bits_left_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			poly_q <= CRCE_RST16;
		end else begin
			if (wr_poly_hi) begin
				poly_q[15:8] <= reg_wdata; // see R1 see R15
			end
			if (wr_poly_lo) begin
				poly_q[7:0] <= reg_wdata;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			int_stat_q <= CRCE_RST8;
			int_mask_q <= CRCE_RST8;
			irq_q <= 1'b0;
			rdata_q <= CRCE_RST8;
			scan_ready_q <= 1'b0;
		end else begin
			int_stat_q <= int_stat_d;
			int_mask_q <= wr_mask ? (reg_wdata & CRCE_IRQ_IMPL) : int_mask_q;
			irq_q <= |(int_stat_d & (wr_mask ? reg_wdata : int_mask_q));
			rdata_q <= reg_rd ? rd_mux : CRCE_RST8;
			// Ready is offered only while the register pair is free next cycle.
			scan_ready_q <= ctrl0_d[CRCE_C0_EN] && !full_d; // see R14
		end
	end

	assign reg_rdata = rdata_q;
	assign scan_ready = scan_ready_q;
	assign irq = irq_q;

	// Checks.
	a_rsvd_zero: assert property (@(posedge core_clk) disable iff (rst) // see R13
		reg_rd && (reg_addr == CRCE_OFS_CTRL0) |=> (reg_rdata[3:2] == 2'b00))
		else $error("control 0 reserved bits read nonzero");

	a_busy_read: assert property (@(posedge core_clk) disable iff (rst) // see R7
		reg_rd && (reg_addr == CRCE_OFS_CTRL0) && !shifter_empty |=> reg_rdata[CRCE_C0_BUSY])
		else $error("busy reads low while shifting");

	a_low_fills: assert property (@(posedge core_clk) disable iff (rst) // see R11
		en && wr_in_lo |=> full_q && (data_q[7:0] == $past(reg_wdata)))
		else $error("low data write did not fill the pair");

	a_load_count: assert property (@(posedge core_clk) disable iff (rst) // see R9
		load && !wr_in_lo && !scan_take
		|=> !full_q && (bits_left_q == {1'b0, $past(wlen_m1)} + CRCE_CNT_ONE))
		else $error("word load count or full flag wrong");

	a_disable_idle: assert property (@(posedge core_clk) disable iff (rst) // see R5
		!en ##1 !en |-> shifter_empty && !full_q && !busy)
		else $error("engine active while disabled");

	a_go_stops: assert property (@(posedge core_clk) disable iff (rst) // see R6
		en && !go && !reg_wr |=> $stable(acc_q) && $stable(bits_left_q))
		else $error("shifter moved with start bit clear");

	a_one_per_clk: assert property (@(posedge core_clk) disable iff (rst) // see R16
		shifting |=> (bits_left_q == $past(bits_left_q) - CRCE_CNT_ONE))
		else $error("shifter did not move exactly one bit");

	a_acc_write: assert property (@(posedge core_clk) disable iff (rst) // see R12
		wr_acc_lo |=> (acc_q[7:0] == $past(reg_wdata)))
		else $error("accumulator low byte write lost");

	a_poly_x0: assert property (@(posedge core_clk) disable iff (rst) // see R15
		reg_rd && (reg_addr == CRCE_OFS_POLY_LO) |=> reg_rdata[0])
		else $error("polynomial term zero reads low");

	a_scan_take: assert property (@(posedge core_clk) disable iff (rst) // see R14
		scan_take |=> full_q && (data_q == $past(scan_data)))
		else $error("scanner word not captured");

	a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
		word_done && int_mask_q[CRCE_IRQ_WORD_DONE] && !wr_mask |=> irq ##0 int_stat_q[0])
		else $error("unmasked word done did not raise interrupt");
endmodule // crce_engine

// >>> tb.sv
`timescale 1ns/100ps
module tb import crce_pkg::*;;
	logic core_clk, rst, reg_wr, reg_rd, scan_valid, scan_ready, irq;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rd_v;
	logic [15:0] scan_data, acc_v, exp_v;
	int err_count, n_compared;
	logic [3:0] pl, wl;
	logic [15:0] pp, sd, d1, d2;
	logic dr, ag;

	crce_engine crce_engine_i(
		.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.scan_valid(scan_valid), .scan_data(scan_data), .scan_ready(scan_ready),
		.irq(irq)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Bit-serial reference; bits above the word length are never fed in.
	function automatic logic [15:0] crc_ref(input logic [15:0] a, p, d, input logic [3:0] l, w,
			input logic r, g);
		logic [15:0] m, q;
		logic b, f;
		m = 16'hFFFF >> (4'hF - l);
		p = p | 16'h0001;
		q = 16'h0000;
		for (int i = 0; i <= l; i++) q[i] = p[l - 4'(i)];
		for (int k = 0; k <= w; k++) begin
			b = r ? d[k] : d[w - 4'(k)];
			f = (r ? a[0] : a[l]) ^ (g & b);
			a = r ? ((a >> 1) | (16'(b & ~g) << l)) : ((a << 1) | 16'(b & ~g));
			a = (a ^ (f ? (r ? q : p) : 16'h0000)) & m;
		end
		return a;
	endfunction

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		rd_v = reg_rdata;
	endtask

	task automatic setup(input logic go);
		wr(CRCE_OFS_CTRL0, {3'b100, ag, 2'b00, dr, 1'b0});
		wr(CRCE_OFS_CTRL1, {wl, pl});
		wr(CRCE_OFS_POLY_HI, pp[15:8]);
		wr(CRCE_OFS_POLY_LO, pp[7:0]);
		wr(CRCE_OFS_ACC_HI, sd[15:8]);
		wr(CRCE_OFS_ACC_LO, sd[7:0]);
		wr(CRCE_OFS_CTRL0, {1'b1, go, 1'b0, ag, 2'b00, dr, 1'b0});
	endtask

	task automatic sw_word(input logic [15:0] d);
		wr(CRCE_OFS_IN_HI, d[15:8]);
		wr(CRCE_OFS_IN_LO, d[7:0]);
	endtask

	// The word must stay on the scanner port until the engine takes it.
	task automatic scan_word(input logic [15:0] d);
		logic tk;
		tk = 1'b0;
		@(posedge core_clk);
		scan_valid <= 1'b1;
		scan_data <= d;
		for (int i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (scan_ready === 1'b1) begin
				tk = 1'b1;
				break;
			end
		end
		scan_valid <= 1'b0;
		scan_data <= ~d;
		chk("scan taken", 16'h0001, {15'h0, tk});
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 60; i++) begin
			rd(CRCE_OFS_CTRL0);
			if ((rd_v & 8'h21) === 8'h00) break;
		end
		chk("idle", 16'h0000, {8'h00, rd_v & 8'h21});
	endtask

	task automatic get_acc();
		rd(CRCE_OFS_ACC_HI);
		acc_v[15:8] = rd_v;
		rd(CRCE_OFS_ACC_LO);
		acc_v[7:0] = rd_v;
	endtask

	initial begin
		repeat (60000) @(posedge core_clk);
		$display("watchdog expired");
		err_count++;
		close_out();
	end

	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, scan_valid} = 3'b000;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		scan_data = 16'h0000;
		err_count = 0;
		n_compared = 0;
		void'($urandom(32'haeb4b157));
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(4'(i < 2 ? i : i + 2));
			chk("reset value", 16'h0000, {8'h00, rd_v});
		end
		wr(4'hC, 8'hFF);
		rd(4'hC);
		chk("unmapped", 16'h0000, {8'h00, rd_v});
		wr(CRCE_OFS_CTRL0, 8'hFF);
		rd(CRCE_OFS_CTRL0);
		chk("ctrl0 read", 16'h00D2, {8'h00, rd_v});
		wr(CRCE_OFS_POLY_LO, 8'h00);
		rd(CRCE_OFS_POLY_LO);
		chk("poly low", 16'h0001, {8'h00, rd_v});
		$display("register test done");

		{pl, wl, pp, sd, dr, ag} = {8'hFF, 16'h8005, 16'hFFFF, 2'b01};
		d1 = 16'h1234;
		d2 = 16'hBEEF;
		setup(1'b0);
		wr(CRCE_OFS_INT_MASK, 8'h03);
		sw_word(d1);
		rd(CRCE_OFS_CTRL0);
		chk("full while stopped", 16'h0001, {15'h0, rd_v[0]});
		wr(CRCE_OFS_CTRL0, 8'hD0);
		sw_word(d2);
		rd(CRCE_OFS_CTRL0);
		chk("full behind busy", 16'h0001, {15'h0, rd_v[0]});
		chk("busy while shifting", 16'h0001, {15'h0, rd_v[CRCE_C0_BUSY]});
		wait_idle();
		get_acc();
		exp_v = crc_ref(crc_ref(sd, pp, d1, pl, wl, dr, ag), pp, d2, pl, wl, dr, ag);
		chk("two words", exp_v, acc_v);
		chk("irq raised", 16'h0001, {15'h0, irq});
		rd(CRCE_OFS_INT_STAT);
		chk("status", 16'h0003, {8'h00, rd_v});
		wr(CRCE_OFS_INT_STAT, 8'h01);
		@(posedge core_clk);
		chk("irq held", 16'h0001, {15'h0, irq});
		wr(CRCE_OFS_INT_STAT, 8'h02);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", 16'h0000, {15'h0, irq});
		wr(CRCE_OFS_INT_MASK, 8'h00);
		$display("back to back test done");

		for (int n = 0; n < 40; n++) begin
			pl = 4'($urandom);
			wl = 4'($urandom);
			pp = 16'($urandom);
			sd = 16'($urandom) & (16'hFFFF >> (4'hF - pl));
			{dr, ag} = 2'($urandom);
			d1 = 16'($urandom);
			setup(1'b1);
			if ($urandom % 2) scan_word(d1);
			else sw_word(d1);
			wait_idle();
			get_acc();
			chk("crc", crc_ref(sd, pp, d1, pl, wl, dr, ag), acc_v);
			chk("masked irq", 16'h0000, {15'h0, irq});
		end
		wr(CRCE_OFS_INT_STAT, 8'h03);
		$display("random test done");

		setup(1'b0);
		sw_word(16'h5A5A);
		wr(CRCE_OFS_CTRL0, 8'h00);
		rd(CRCE_OFS_CTRL0);
		chk("disabled", 16'h0000, {8'h00, rd_v});
		chk("ready off", 16'h0000, {15'h0, scan_ready});
		get_acc();
		chk("acc kept", sd, acc_v);
		$display("disable test done");
		close_out();
	end
endmodule // tb
